// file: design/amcr_pkg.sv
// Purpose: Constants and types for the amplifier configuration register bank
// Assumes: Byte-wide register port fed by the serial bus slave on CLK_SYS
// Notes: Register offsets are byte addresses on the register port
package amcr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_LEFT_GAIN = 8'h20;
  localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h21;
  localparam logic [7:0] ADDR_PWM_OPTIONS = 8'h41;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'hFF;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hFF;
  // Reset values
  localparam logic [7:0] RST_DATA = 8'h08;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_PWM_OPTIONS = 8'h03;
  // Writable bit masks and fixed bits
  localparam logic [7:0] MASK_DATA = 8'h7F;
  localparam logic [7:0] MASK_PWM_OPTIONS = 8'h0E;
  localparam logic [7:0] FIXED_PWM_OPTIONS = 8'h01;
  // Field positions
  localparam int DATA_RATE_LSB = 3;
  localparam int DATA_RATIO_LSB = 5;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_MUTE_N_BIT = 6;
  localparam int GAIN_HALT_BIT = 7;
  localparam int PWM_IDLE_BIT = 1;
  localparam int PWM_INDEX_BIT = 2;
  localparam int PWM_ORDER_BIT = 3;
  // Strap vector layout
  localparam int PIN_W = 13;
  localparam int PIN_RATIO_LSB = 0;
  localparam int PIN_RATE_LSB = 2;
  localparam int PIN_GAIN_LSB = 4;
  localparam int PIN_MUTE_N_BIT = 10;
  localparam int PIN_MODE_BIT = 11;
  localparam int PIN_FS_OK_BIT = 12;
  // Master clock multiples at base rates, and gain codes
  localparam logic [9:0] FS_MULT_R0 = 10'h100;
  localparam logic [9:0] FS_MULT_R1 = 10'h180;
  localparam logic [9:0] FS_MULT_R2 = 10'h200;
  localparam logic [9:0] FS_MULT_R3 = 10'h300;
  localparam logic [1:0] RATE_DOUBLE = 2'h2;
  localparam logic [1:0] RATE_QUAD = 2'h3;
  localparam logic [5:0] GAIN_CODE_MUTE = 6'h00;

  typedef struct packed {
    logic [1:0] mclk_ratio;
    logic [1:0] sample_rate;
    logic [9:0] fs_mult;
    logic [5:0] left_gain;
    logic [5:0] right_gain;
    logic left_mute;
    logic right_mute;
    logic left_halt;
    logic right_halt;
    logic idle_pulse;
    logic mod_index;
    logic shaper_order;
  } amcr_out_type;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [7:0] data_reg;
    logic [7:0] left_reg;
    logic [7:0] right_reg;
    logic [7:0] pwm_reg;
    logic [7:0] last_addr;
    logic [7:0] rd_data;
    amcr_out_type outs;
  } amcr_state_type;
endpackage

// file: design/amcr_config_regs.sv
// Purpose: Configuration register bank of a two-channel class-D amplifier
// Assumes: Register port driven by the serial bus slave on CLK_SYS; straps are async pins
// Notes: Effective settings are registered; pins pass two flip-flops first
// Operation
// - Ratio register used only when ratio strap low
// - Rate register used only when rate strap low
// - Base rates: ratio codes give 256/384/512/768 fs
// - Double rate halves, quad rate quarters multiples
// - Mismatched clock or rate switches output off
// - Six-bit gain per channel, 64 steps
// - Gain code zero mutes the channel
// - Gain registers used only when gain straps low
// - Mute bits active low per channel
// - Mute bits used only when mute strap low
// - Halt bit one stops channel PWM
// - Idle pulse bit selects idle or 50% duty
// - Index bit selects 87.5% or 100%
// - Order bit selects seventh or fifth order
// - Writing FFh at FFh restores data, gain and PWM registers
`timescale 1ns/100ps
module amcr_config_regs (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Register port from the bus slave
  input wire logic REG_WR_EN,
  input wire logic [7:0] REG_WR_ADDR,
  input wire logic [7:0] REG_WR_DATA,
  input wire logic REG_RD_EN,
  input wire logic [7:0] REG_RD_ADDR,
  output logic [7:0] REG_RD_DATA,
  // Strap pins
  input wire logic PIN_MODE_ONLY,
  input wire logic [1:0] MCLK_RATIO_STRAP,
  input wire logic [1:0] SAMPLE_RATE_STRAP,
  input wire logic [5:0] GAIN_STRAP,
  input wire logic MUTE_N_STRAP,
  input wire logic FS_MATCH_OK,
  // Effective settings
  output logic [1:0] EFF_MCLK_RATIO,
  output logic [1:0] EFF_SAMPLE_RATE,
  output logic [9:0] MCLK_FS_MULT,
  output logic [5:0] LEFT_GAIN,
  output logic [5:0] RIGHT_GAIN,
  output logic LEFT_MUTE,
  output logic RIGHT_MUTE,
  output logic LEFT_PWM_HALT,
  output logic RIGHT_PWM_HALT,
  output logic IDLE_PULSE_SEL,
  output logic MOD_INDEX_SEL,
  output logic SHAPER_ORDER_SEL
);

  amcr_pkg::amcr_state_type s_q;
  amcr_pkg::amcr_state_type s_d;

  // Master clock multiple for a rate and ratio code
  function automatic logic [9:0] fs_mult_f(input logic [1:0] rate, input logic [1:0] ratio);
    logic [9:0] base;
    base = amcr_pkg::FS_MULT_R0;
    unique case (ratio)
      2'h0: base = amcr_pkg::FS_MULT_R0;
      2'h1: base = amcr_pkg::FS_MULT_R1;
      2'h2: base = amcr_pkg::FS_MULT_R2;
      2'h3: base = amcr_pkg::FS_MULT_R3;
    endcase
    if (rate == amcr_pkg::RATE_DOUBLE) begin
      base = base >> 1;
    end else if (rate == amcr_pkg::RATE_QUAD) begin
      base = base >> 2;
    end
    return base;
  endfunction

  // Register or strap, whichever the mode and pin allow
  function automatic logic use_reg_f(input logic pin_only, input logic strap_set);
    return !pin_only && !strap_set;
  endfunction

  logic [amcr_pkg::PIN_W-1:0] pins;
  logic pin_only;
  logic [1:0] s_ratio;
  logic [1:0] s_rate;
  logic [5:0] s_gain;
  logic s_mute_n;
  logic fs_ok;
  logic [1:0] r_ratio;
  logic [1:0] r_rate;
  logic [1:0] e_ratio;
  logic [1:0] e_rate;
  logic [5:0] l_gain;
  logic [5:0] r_gain;
  logic l_mute_n;
  logic r_mute_n;
  logic soft_rst;

  assign pins = {FS_MATCH_OK, PIN_MODE_ONLY, MUTE_N_STRAP, GAIN_STRAP, SAMPLE_RATE_STRAP,
                 MCLK_RATIO_STRAP};
  assign pin_only = s_q.sync2[amcr_pkg::PIN_MODE_BIT];
  assign s_ratio = s_q.sync2[amcr_pkg::PIN_RATIO_LSB +: 2];
  assign s_rate = s_q.sync2[amcr_pkg::PIN_RATE_LSB +: 2];
  assign s_gain = s_q.sync2[amcr_pkg::PIN_GAIN_LSB +: 6];
  assign s_mute_n = s_q.sync2[amcr_pkg::PIN_MUTE_N_BIT];
  assign fs_ok = s_q.sync2[amcr_pkg::PIN_FS_OK_BIT];
  assign r_ratio = s_q.data_reg[amcr_pkg::DATA_RATIO_LSB +: 2];
  assign r_rate = s_q.data_reg[amcr_pkg::DATA_RATE_LSB +: 2];
  // Written with the bus slave's own ordering: address then data
  assign soft_rst = REG_WR_EN && REG_WR_ADDR == amcr_pkg::ADDR_SOFT_RESET &&
                    REG_WR_DATA == amcr_pkg::SOFT_RESET_KEY;

  // Any strap bit high hands the setting to the pins
  assign e_ratio = use_reg_f(pin_only, |s_ratio) ? r_ratio : s_ratio;
  assign e_rate = use_reg_f(pin_only, |s_rate) ? r_rate : s_rate;
  assign l_gain = use_reg_f(pin_only, |s_gain) ?
                  s_q.left_reg[amcr_pkg::GAIN_LSB +: 6] : s_gain;
  assign r_gain = use_reg_f(pin_only, |s_gain) ?
                  s_q.right_reg[amcr_pkg::GAIN_LSB +: 6] : s_gain;
  assign l_mute_n = use_reg_f(pin_only, s_mute_n) ?
                    s_q.left_reg[amcr_pkg::GAIN_MUTE_N_BIT] : s_mute_n;
  assign r_mute_n = use_reg_f(pin_only, s_mute_n) ?
                    s_q.right_reg[amcr_pkg::GAIN_MUTE_N_BIT] : s_mute_n;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    // Register writes; the host is expected to mute first
    if (soft_rst) begin
      s_d.data_reg = amcr_pkg::RST_DATA;
      s_d.left_reg = amcr_pkg::RST_GAIN;
      s_d.right_reg = amcr_pkg::RST_GAIN;
      s_d.pwm_reg = amcr_pkg::RST_PWM_OPTIONS;
    end else if (REG_WR_EN) begin
      unique case (REG_WR_ADDR)
        amcr_pkg::ADDR_DATA: s_d.data_reg = REG_WR_DATA & amcr_pkg::MASK_DATA;
        amcr_pkg::ADDR_LEFT_GAIN: s_d.left_reg = REG_WR_DATA;
        amcr_pkg::ADDR_RIGHT_GAIN: s_d.right_reg = REG_WR_DATA;
        amcr_pkg::ADDR_PWM_OPTIONS: begin
          s_d.pwm_reg = (REG_WR_DATA & amcr_pkg::MASK_PWM_OPTIONS) |
                        amcr_pkg::FIXED_PWM_OPTIONS;
        end
        default: s_d.pwm_reg = s_q.pwm_reg;
      endcase
    end
    if (REG_WR_EN) begin
      s_d.last_addr = REG_WR_ADDR;
    end else if (REG_RD_EN) begin
      s_d.last_addr = REG_RD_ADDR;
    end
    // Read data; unmapped and write-only locations read zero
    if (REG_RD_EN) begin
      unique case (REG_RD_ADDR)
        amcr_pkg::ADDR_STATUS: s_d.rd_data = s_q.last_addr;
        amcr_pkg::ADDR_DATA: s_d.rd_data = s_q.data_reg;
        amcr_pkg::ADDR_LEFT_GAIN: s_d.rd_data = s_q.left_reg;
        amcr_pkg::ADDR_RIGHT_GAIN: s_d.rd_data = s_q.right_reg;
        amcr_pkg::ADDR_PWM_OPTIONS: s_d.rd_data = s_q.pwm_reg;
        default: s_d.rd_data = 8'h00;
      endcase
    end
    // Effective settings
    s_d.outs.mclk_ratio = e_ratio;
    s_d.outs.sample_rate = e_rate;
    s_d.outs.fs_mult = fs_mult_f(e_rate, e_ratio);
    s_d.outs.left_gain = l_gain;
    s_d.outs.right_gain = r_gain;
    s_d.outs.left_mute = !l_mute_n || l_gain == amcr_pkg::GAIN_CODE_MUTE;
    s_d.outs.right_mute = !r_mute_n || r_gain == amcr_pkg::GAIN_CODE_MUTE;
    // Clock mismatch stops both channels rather than play garbage
    s_d.outs.left_halt = s_q.left_reg[amcr_pkg::GAIN_HALT_BIT] || !fs_ok;
    s_d.outs.right_halt = s_q.right_reg[amcr_pkg::GAIN_HALT_BIT] || !fs_ok;
    s_d.outs.idle_pulse = s_q.pwm_reg[amcr_pkg::PWM_IDLE_BIT];
    s_d.outs.mod_index = s_q.pwm_reg[amcr_pkg::PWM_INDEX_BIT];
    s_d.outs.shaper_order = s_q.pwm_reg[amcr_pkg::PWM_ORDER_BIT];
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '0;
      s_q.data_reg <= amcr_pkg::RST_DATA;
      s_q.left_reg <= amcr_pkg::RST_GAIN;
      s_q.right_reg <= amcr_pkg::RST_GAIN;
      s_q.pwm_reg <= amcr_pkg::RST_PWM_OPTIONS;
      // Reset outputs give base multiple and gain zero muted; sample rate and idle pulse reset to zero, unlike the registers
      s_q.outs.fs_mult <= amcr_pkg::FS_MULT_R0;
      s_q.outs.left_mute <= 1'b1;
      s_q.outs.right_mute <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RD_DATA = s_q.rd_data;
  assign EFF_MCLK_RATIO = s_q.outs.mclk_ratio;
  assign EFF_SAMPLE_RATE = s_q.outs.sample_rate;
  assign MCLK_FS_MULT = s_q.outs.fs_mult;
  assign LEFT_GAIN = s_q.outs.left_gain;
  assign RIGHT_GAIN = s_q.outs.right_gain;
  assign LEFT_MUTE = s_q.outs.left_mute;
  assign RIGHT_MUTE = s_q.outs.right_mute;
  assign LEFT_PWM_HALT = s_q.outs.left_halt;
  assign RIGHT_PWM_HALT = s_q.outs.right_halt;
  assign IDLE_PULSE_SEL = s_q.outs.idle_pulse;
  assign MOD_INDEX_SEL = s_q.outs.mod_index;
  assign SHAPER_ORDER_SEL = s_q.outs.shaper_order;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  sequence soft_reset_seq;
    REG_WR_EN && REG_WR_ADDR == 8'hFF && REG_WR_DATA == 8'hFF;
  endsequence

  a_ratio_reg_used: assert property (!pin_only && s_ratio == 2'h0 |=>
    EFF_MCLK_RATIO == $past(r_ratio)) else $error("ratio register not applied");
  a_rate_pin_used: assert property (pin_only || s_rate != 2'h0 |=>
    EFF_SAMPLE_RATE == $past(s_rate)) else $error("rate strap not applied");
  a_base_mult: assert property (EFF_SAMPLE_RATE[1] == 1'b0 |->
    MCLK_FS_MULT == (EFF_MCLK_RATIO == 2'h0 ? 10'd256 : EFF_MCLK_RATIO == 2'h1 ? 10'd384 :
    EFF_MCLK_RATIO == 2'h2 ? 10'd512 : 10'd768)) else $error("base fs multiple wrong");
  a_quad_mult: assert property (EFF_SAMPLE_RATE == 2'h3 && EFF_MCLK_RATIO == 2'h0 |->
    MCLK_FS_MULT == 10'd64) else $error("quad rate multiple wrong");
  a_mismatch_halt: assert property (!fs_ok |=> LEFT_PWM_HALT && RIGHT_PWM_HALT)
    else $error("mismatch did not halt output");
  a_gain_zero_mute: assert property (LEFT_GAIN == 6'h00 |-> LEFT_MUTE)
    else $error("gain code zero not muted");
  a_gain_reg_used: assert property (!pin_only && s_gain == 6'h00 |=>
    RIGHT_GAIN == $past(s_q.right_reg[5:0])) else $error("gain register not applied");
  a_mute_pin_used: assert property (pin_only && !s_mute_n |=> LEFT_MUTE && RIGHT_MUTE)
    else $error("mute strap not applied");
  a_halt_bit: assert property (REG_WR_EN && REG_WR_ADDR == 8'h20 && REG_WR_DATA[7]
    ##1 !REG_WR_EN |=> LEFT_PWM_HALT) else $error("halt bit not applied");
  a_pwm_opts: assert property (REG_WR_EN && REG_WR_ADDR == 8'h41 ##1 !REG_WR_EN
    |=> MOD_INDEX_SEL == $past(REG_WR_DATA[amcr_pkg::PWM_INDEX_BIT], 2))
    else $error("index not applied");
  a_soft_reset: assert property (soft_reset_seq |=>
    s_q.data_reg == 8'h08 && s_q.left_reg == 8'h00 && s_q.pwm_reg == 8'h03)
    else $error("soft reset did not restore registers");

endmodule // amcr_config_regs

// file: test/amcr_host_model.sv
// Purpose: Host model that writes and reads the configuration registers
// Assumes: Bank samples its register port on the rising edge
// Notes: Drives at the falling edge; released lines show inverted values
`timescale 1ns/100ps
module amcr_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end

  // Address then data in one strobe, as the bus slave delivers them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    rd_addr = ~a;
    d = rd_data;
  endtask
endmodule // amcr_host_model

// file: test/tb.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Settings follow two edges after a write, pins three edges
// Notes: Waits four cycles before looking at effective settings
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wr_en, rd_en;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, rdv;
  logic mode_only = 1'b0;
  logic [1:0] ratio_pin = 2'h0;
  logic [1:0] rate_pin = 2'h0;
  logic [5:0] gain_pin = 6'h00;
  logic mute_n_pin = 1'b0;
  logic fs_ok = 1'b1;
  logic [1:0] eff_ratio, eff_rate;
  logic [9:0] fs_mult;
  logic [5:0] l_gain, r_gain;
  logic l_mute, r_mute, l_halt, r_halt, idle_sel, index_sel, order_sel;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  always #25 clk_sys = ~clk_sys;

  amcr_host_model i_amcr_host_model (.clk(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));

  amcr_config_regs i_amcr_config_regs (.CLK_SYS(clk_sys), .ARST_N(arst_n),
    .REG_WR_EN(wr_en), .REG_WR_ADDR(wr_addr), .REG_WR_DATA(wr_data), .REG_RD_EN(rd_en),
    .REG_RD_ADDR(rd_addr), .REG_RD_DATA(rd_data), .PIN_MODE_ONLY(mode_only),
    .MCLK_RATIO_STRAP(ratio_pin), .SAMPLE_RATE_STRAP(rate_pin), .GAIN_STRAP(gain_pin),
    .MUTE_N_STRAP(mute_n_pin), .FS_MATCH_OK(fs_ok), .EFF_MCLK_RATIO(eff_ratio),
    .EFF_SAMPLE_RATE(eff_rate), .MCLK_FS_MULT(fs_mult), .LEFT_GAIN(l_gain),
    .RIGHT_GAIN(r_gain), .LEFT_MUTE(l_mute), .RIGHT_MUTE(r_mute), .LEFT_PWM_HALT(l_halt),
    .RIGHT_PWM_HALT(r_halt), .IDLE_PULSE_SEL(idle_sel), .MOD_INDEX_SEL(index_sel),
    .SHAPER_ORDER_SEL(order_sel));

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic settle;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic report_and_stop;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic t_reset;
    logic [7:0] a [6] = '{8'h10, 8'h20, 8'h21, 8'h41, 8'h30, 8'hFF};
    logic [7:0] e [6] = '{amcr_pkg::RST_DATA, 8'h00, 8'h00, amcr_pkg::RST_PWM_OPTIONS, 8'h00,
      8'h00};
    for (int i = 0; i < 6; i++) begin
      i_amcr_host_model.rd(a[i], rdv);
      chk("reset read", {2'h0, e[i]}, {2'h0, rdv});
    end
    $display("test reset done");
  endtask

  task automatic t_ratio;
    logic [9:0] m [4] = '{amcr_pkg::FS_MULT_R0, amcr_pkg::FS_MULT_R1, amcr_pkg::FS_MULT_R2,
      amcr_pkg::FS_MULT_R3};
    // Channels stay muted from reset while the clocking changes
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 4; s++) begin
        i_amcr_host_model.wr(8'h10, {1'b0, r[1:0], s[1:0], 3'h0});
        settle();
        chk("ratio", {8'h00, r[1:0]}, {8'h00, eff_ratio});
        chk("rate", {8'h00, s[1:0]}, {8'h00, eff_rate});
        chk("fs_mult", m[r] >> ((s == 3) ? 2 : (s == 2) ? 1 : 0), fs_mult);
      end
    end
    i_amcr_host_model.wr(8'h10, 8'hFF);
    i_amcr_host_model.rd(8'h10, rdv);
    chk("data readback", 10'h07F, {2'h0, rdv});
    $display("test ratio done");
  endtask

  task automatic t_gain;
    logic [5:0] c [4] = '{6'h00, 6'h01, 6'h37, 6'h3F};
    for (int i = 0; i < 4; i++) begin
      i_amcr_host_model.wr(8'h20, {2'h1, c[i]});
      i_amcr_host_model.wr(8'h21, {2'h1, ~c[i]});
      settle();
      chk("left gain", {4'h0, c[i]}, {4'h0, l_gain});
      chk("left mute", {9'h0, c[i] == 6'h00}, {9'h0, l_mute});
      chk("right gain", {4'h0, ~c[i]}, {4'h0, r_gain});
      chk("right mute", {9'h0, c[i] == 6'h3F}, {9'h0, r_mute});
    end
    i_amcr_host_model.wr(8'h20, 8'h81);
    settle();
    chk("mute bit low", 10'h001, {9'h0, l_mute});
    chk("left halt", 10'h001, {9'h0, l_halt});
    chk("right run", 10'h000, {9'h0, r_halt});
    fs_ok = 1'b0;
    settle();
    chk("mismatch halt", 10'h001, {9'h0, r_halt});
    fs_ok = 1'b1;
    $display("test gain done");
  endtask

  task automatic t_strap;
    ratio_pin = 2'h1;
    rate_pin = 2'h2;
    mute_n_pin = 1'b1;
    gain_pin = 6'h05;
    settle();
    chk("ratio pin", 10'h001, {8'h00, eff_ratio});
    chk("rate pin", 10'h002, {8'h00, eff_rate});
    chk("mute pin", 10'h000, {9'h0, l_mute});
    chk("gain pin", 10'h005, {4'h0, l_gain});
    ratio_pin = 2'h0;
    rate_pin = 2'h0;
    mode_only = 1'b1;
    settle();
    chk("pin mode", 10'h000, {8'h00, eff_ratio});
    mode_only = 1'b0;
    mute_n_pin = 1'b0;
    gain_pin = 6'h00;
    settle();
    chk("reg again", 10'h003, {8'h00, eff_rate});
    chk("gain again", 10'h001, {4'h0, l_gain});
    $display("test strap done");
  endtask

  task automatic t_pwm_soft;
    for (int v = 0; v < 8; v++) begin
      i_amcr_host_model.wr(8'h41, {4'hF, v[2:0], 1'b0});
      settle();
      chk("idle", {9'h0, v[0]}, {9'h0, idle_sel});
      chk("index", {9'h0, v[1]}, {9'h0, index_sel});
      chk("order", {9'h0, v[2]}, {9'h0, order_sel});
      i_amcr_host_model.rd(8'h41, rdv);
      chk("pwm readback", {6'h0, v[2:0], 1'b1}, {2'h0, rdv});
    end
    i_amcr_host_model.wr(8'hFF, 8'hFE);
    i_amcr_host_model.rd(8'h41, rdv);
    chk("wrong key", 10'h00F, {2'h0, rdv});
    i_amcr_host_model.rd(8'h00, rdv);
    chk("status", 10'h041, {2'h0, rdv});
    i_amcr_host_model.wr(8'hFF, 8'hFF);
    settle();
    chk("soft idle", 10'h001, {9'h0, idle_sel});
    chk("soft halt", 10'h000, {9'h0, l_halt});
    t_reset();
    $display("test pwm and soft reset done");
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    t_reset();
    t_ratio();
    t_gain();
    t_strap();
    t_pwm_soft();
    report_and_stop();
  end
endmodule // tb
